// >>> rtl/cbgc_bank.v
// Cathode bias override and per-channel gain register bank
`timescale 1ns/100ps
`default_nettype none
`include "cbgc_defines.vh"

// How it works
// - Override bit picks per-phase cathode fields
// - Sleep field sets cathode in sleep, idle
// - Slot B field sets cathode in slot B
// - Slot A field, same codes as B
// - Anode reference from slot's own vref field
// - Slot B per-channel gains need enable
// - Slot A per-channel gains need enable
// - Gain codes map to 200k..25k ohms
// - Global bit gives 1.3 V or 1.8 V
// - Channel 1 always from main gain
// - Disabled: main gain for all channels
module cbgc_bank (
  input wire clock, // 40 MHz system clock
  input wire reset, // Synchronous, active high
  input wire [7:0] reg_addr, // Register address from serial port
  input wire [15:0] reg_wdata, // Write data
  input wire reg_wr, // Write strobe, one cycle
  input wire reg_rd, // Read strobe, one cycle
  output reg [15:0] reg_rdata, // Read data, valid after reg_rd
  input wire global_cathode, // Global cathode bit of config bank
  input wire [1:0] phase, // Current operating phase
  input wire slot_a_individual_gain_enable, // Slot A individual gain on
  input wire slot_b_individual_gain_enable, // Slot B individual gain on
  input wire [1:0] slot_a_main_gain, // Slot A main gain code
  input wire [1:0] slot_b_main_gain, // Slot B main gain code
  input wire [1:0] slot_a_vref, // Slot A anode reference code
  input wire [1:0] slot_b_vref, // Slot B anode reference code
  output reg [2:0] cathode_sel, // Cathode drive selection
  output reg [1:0] anode_vref_sel, // Anode reference code in use
  output reg [3:0] ch1_rsel, // Channel 1 resistor, one-hot
  output reg [3:0] ch2_rsel, // Channel 2 resistor, one-hot
  output reg [3:0] ch3_rsel, // Channel 3 resistor, one-hot
  output reg [3:0] ch4_rsel // Channel 4 resistor, one-hot
);

  reg [15:0] cathode_bias_override_reg;
  reg [15:0] channel_gain_select_reg;
  reg [2:0] cathode_next;
  reg [1:0] vref_next;
  wire [7:0] gains_a;
  wire [7:0] gains_b;
  reg [7:0] gains_now;
  wire cathode_override_enable;
  wire [1:0] sleep_cathode_select;
  wire [1:0] slot_b_cathode_select;
  wire [1:0] slot_a_cathode_select;
  wire [1:0] addr_hit;
  reg [3:0] ch1_next;
  reg [3:0] ch2_next;
  reg [3:0] ch3_next;
  reg [3:0] ch4_next;

  function [3:0] gain_rsel;
    input [1:0] code;
    begin
      case (code)
        2'h0: gain_rsel = `CBGC_RSEL_200K;
        2'h1: gain_rsel = `CBGC_RSEL_100K;
        2'h2: gain_rsel = `CBGC_RSEL_50K;
        default: gain_rsel = `CBGC_RSEL_25K;
      endcase
    end
  endfunction

  // Slot codes 0 and 3 match sleep codes; 1 and 2 differ
  function [2:0] slot_cathode;
    input [1:0] code;
    begin
      case (code)
        2'h0: slot_cathode = `CBGC_CAT_VDD;
        2'h1: slot_cathode = `CBGC_CAT_ANODE;
        2'h2: slot_cathode = `CBGC_CAT_REV250;
        default: slot_cathode = `CBGC_CAT_ZERO;
      endcase
    end
  endfunction

  // Address decode shared by write and read paths
  function [1:0] addr_decode;
    input [7:0] addr;
    begin
      if (addr == `CBGC_OFS_CATHODE_OVR) begin
        addr_decode = 2'h1;
      end else if (addr == `CBGC_OFS_GAIN_SEL) begin
        addr_decode = 2'h2;
      end else begin
        addr_decode = 2'h0;
      end
    end
  endfunction

  assign cathode_override_enable = cathode_bias_override_reg[`CBGC_BIT_OVR_EN];
  assign sleep_cathode_select =
    cathode_bias_override_reg[`CBGC_SLEEP_CAT_HI:`CBGC_SLEEP_CAT_LO];
  assign slot_b_cathode_select =
    cathode_bias_override_reg[`CBGC_SLOTB_CAT_HI:`CBGC_SLOTB_CAT_LO];
  assign slot_a_cathode_select =
    cathode_bias_override_reg[`CBGC_SLOTA_CAT_HI:`CBGC_SLOTA_CAT_LO];

  assign addr_hit = addr_decode(reg_addr);

  cbgc_slot_gain u_slot_a (
    .ind_en(slot_a_individual_gain_enable),
    .main_gain(slot_a_main_gain),
    .ch2_gain(channel_gain_select_reg[`CBGC_A_CH2_LO+1:`CBGC_A_CH2_LO]),
    .ch3_gain(channel_gain_select_reg[`CBGC_A_CH3_LO+1:`CBGC_A_CH3_LO]),
    .ch4_gain(channel_gain_select_reg[`CBGC_A_CH4_LO+1:`CBGC_A_CH4_LO]),
    .gains(gains_a)
  );

  cbgc_slot_gain u_slot_b (
    .ind_en(slot_b_individual_gain_enable),
    .main_gain(slot_b_main_gain),
    .ch2_gain(channel_gain_select_reg[`CBGC_B_CH2_LO+1:`CBGC_B_CH2_LO]),
    .ch3_gain(channel_gain_select_reg[`CBGC_B_CH3_LO+1:`CBGC_B_CH3_LO]),
    .ch4_gain(channel_gain_select_reg[`CBGC_B_CH4_LO+1:`CBGC_B_CH4_LO]),
    .gains(gains_b)
  );

  // Idle and sleep keep slot A routing, so the amplifiers never see an undefined gain
  always @* begin
    if (phase == `CBGC_PH_SLOT_B) begin
      gains_now = gains_b;
    end else begin
      gains_now = gains_a;
    end
    ch1_next = gain_rsel(gains_now[1:0]);
    ch2_next = gain_rsel(gains_now[3:2]);
    ch3_next = gain_rsel(gains_now[5:4]);
    ch4_next = gain_rsel(gains_now[7:6]);
  end

  always @* begin
    cathode_next = `CBGC_CAT_VDD;
    if (phase == `CBGC_PH_SLOT_B) begin
      vref_next = slot_b_vref;
    end else begin
      vref_next = slot_a_vref;
    end
    if (!cathode_override_enable) begin
      cathode_next = global_cathode ? `CBGC_CAT_1V8 : `CBGC_CAT_1V3;
    end else if (phase == `CBGC_PH_SLOT_B) begin
      cathode_next = slot_cathode(slot_b_cathode_select);
    end else if (phase == `CBGC_PH_SLOT_A) begin
      cathode_next = slot_cathode(slot_a_cathode_select);
    end else begin
      // sleep field, code 1 splits idle and sleep
      case (sleep_cathode_select)
        2'h0: cathode_next = `CBGC_CAT_VDD;
        2'h1: cathode_next = (phase == `CBGC_PH_IDLE) ? `CBGC_CAT_VREF : `CBGC_CAT_VDD;
        2'h2: cathode_next = `CBGC_CAT_FLOAT;
        default: cathode_next = `CBGC_CAT_ZERO;
      endcase
    end
  end

  // Reserved bits are not stored, so a stray write cannot steer anything
  always @(posedge clock) begin
    if (reset) begin
      cathode_bias_override_reg <= `CBGC_RST_CATHODE_OVR;
      channel_gain_select_reg <= `CBGC_RST_GAIN_SEL;
    end else if (reg_wr) begin
      if (addr_hit[0]) begin
        cathode_bias_override_reg <= reg_wdata & `CBGC_MASK_CATHODE_OVR;
      end else if (addr_hit[1]) begin
        channel_gain_select_reg <= reg_wdata & `CBGC_MASK_GAIN_SEL;
      end
    end
  end

  // Read data holds until the next read strobe; unknown addresses read zero
  always @(posedge clock) begin
    if (reset) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      if (addr_hit[0]) begin
        reg_rdata <= cathode_bias_override_reg;
      end else if (addr_hit[1]) begin
        reg_rdata <= channel_gain_select_reg;
      end else begin
        reg_rdata <= 16'h0000;
      end
    end
  end

  // Selections registered so the analog side never sees decode glitches
  always @(posedge clock) begin
    if (reset) begin
      cathode_sel <= `CBGC_CAT_1V3;
      anode_vref_sel <= 2'h0;
      ch1_rsel <= `CBGC_RSEL_200K;
      ch2_rsel <= `CBGC_RSEL_200K;
      ch3_rsel <= `CBGC_RSEL_200K;
      ch4_rsel <= `CBGC_RSEL_200K;
    end else begin
      cathode_sel <= cathode_next;
      anode_vref_sel <= vref_next;
      ch1_rsel <= ch1_next;
      ch2_rsel <= ch2_next;
      ch3_rsel <= ch3_next;
      ch4_rsel <= ch4_next;
    end
  end

endmodule // cbgc_bank

`default_nettype wire

// >>> rtl/cbgc_defines.vh
// Offsets, field positions, reset values and codes of the cathode bias and gain bank
`ifndef CBGC_DEFINES_VH
`define CBGC_DEFINES_VH

`define CBGC_ADDR_W 8
`define CBGC_DATA_W 16

`define CBGC_OFS_CATHODE_OVR 8'h54
`define CBGC_OFS_GAIN_SEL 8'h55

`define CBGC_RST_CATHODE_OVR 16'h0020
`define CBGC_RST_GAIN_SEL 16'h0000

// Writable bits; reserved upper bits read back as zero
`define CBGC_MASK_CATHODE_OVR 16'h3FFF
`define CBGC_MASK_GAIN_SEL 16'h0FFF

`define CBGC_BIT_OVR_EN 7
`define CBGC_SLEEP_CAT_HI 13
`define CBGC_SLEEP_CAT_LO 12
`define CBGC_SLOTB_CAT_HI 11
`define CBGC_SLOTB_CAT_LO 10
`define CBGC_SLOTA_CAT_HI 9
`define CBGC_SLOTA_CAT_LO 8

`define CBGC_B_CH4_LO 10
`define CBGC_B_CH3_LO 8
`define CBGC_B_CH2_LO 6
`define CBGC_A_CH4_LO 4
`define CBGC_A_CH3_LO 2
`define CBGC_A_CH2_LO 0

// Operating phase
`define CBGC_PH_IDLE 2'h0
`define CBGC_PH_SLEEP 2'h1
`define CBGC_PH_SLOT_A 2'h2
`define CBGC_PH_SLOT_B 2'h3

// Cathode drive selection to the analog side
`define CBGC_CAT_VDD 3'h0
`define CBGC_CAT_VREF 3'h1
`define CBGC_CAT_FLOAT 3'h2
`define CBGC_CAT_ZERO 3'h3
`define CBGC_CAT_ANODE 3'h4
`define CBGC_CAT_REV250 3'h5
`define CBGC_CAT_1V3 3'h6
`define CBGC_CAT_1V8 3'h7

// One-hot feedback resistor select: bit0 200k, bit1 100k, bit2 50k, bit3 25k
`define CBGC_RSEL_200K 4'h1
`define CBGC_RSEL_100K 4'h2
`define CBGC_RSEL_50K 4'h4
`define CBGC_RSEL_25K 4'h8

`endif

// >>> rtl/cbgc_slot_gain.v
// Channel gain routing for one time slot
`timescale 1ns/100ps
`default_nettype none

module cbgc_slot_gain (
  input wire ind_en, // Individual gain enable of the slot
  input wire [1:0] main_gain, // Slot main gain code
  input wire [1:0] ch2_gain, // Individual code, channel 2
  input wire [1:0] ch3_gain, // Individual code, channel 3
  input wire [1:0] ch4_gain, // Individual code, channel 4
  output wire [7:0] gains // Codes, channel 4 in top bits
);

  // main code to all when disabled
  assign gains = ind_en ? {ch4_gain, ch3_gain, ch2_gain, main_gain}
                        : {main_gain, main_gain, main_gain, main_gain};

endmodule // cbgc_slot_gain

`default_nettype wire

// >>> tb/cbgc_chk.sv
// Assertion checker for the cathode bias and gain bank
`timescale 1ns/100ps
`default_nettype none
module cbgc_chk (
  input wire logic clock, // Clock
  input wire logic reset, // Reset
  input wire logic [7:0] reg_addr, // Address
  input wire logic [15:0] reg_wdata, // Write data
  input wire logic reg_wr, // Write
  input wire logic reg_rd, // Read
  input wire logic [15:0] reg_rdata, // Read data
  input wire logic global_cathode, // Global bit
  input wire logic [1:0] phase, // Phase
  input wire logic slot_a_individual_gain_enable, // A enable
  input wire logic slot_b_individual_gain_enable, // B enable
  input wire logic [1:0] slot_a_main_gain, // A gain
  input wire logic [1:0] slot_b_main_gain, // B gain
  input wire logic [1:0] slot_a_vref, // A ref
  input wire logic [1:0] slot_b_vref, // B ref
  input wire logic [2:0] cathode_sel, // Cathode
  input wire logic [1:0] anode_vref_sel, // Anode ref
  input wire logic [3:0] ch1_rsel, // Ch1
  input wire logic [3:0] ch2_rsel, // Ch2
  input wire logic [3:0] ch3_rsel, // Ch3
  input wire logic [3:0] ch4_rsel // Ch4
);
  logic [15:0] ovr_q, gain_q;
  wire b = phase == 2'h3;
  wire en = b ? slot_b_individual_gain_enable : slot_a_individual_gain_enable;
  wire [1:0] mg = b ? slot_b_main_gain : slot_a_main_gain;
  wire [5:0] cd = en ? (b ? gain_q[11:6] : gain_q[5:0]) : {3{mg}};
  wire [11:0] exp_g = {4'h1 << cd[5:4], 4'h1 << cd[3:2], 4'h1 << cd[1:0]};
  wire [1:0] sc = ovr_q[13:12];
  wire [2:0] slp = sc == 2'h1 ? {2'h0, phase == 2'h0} : {1'b0, sc};
  wire [15:0] rd_exp = reg_addr == 8'h54 ? ovr_q : reg_addr == 8'h55 ? gain_q : 16'h0000;
  function automatic logic [2:0] smap(input logic [1:0] c);
    return c == 2'h1 ? 3'h4 : c == 2'h2 ? 3'h5 : {1'b0, c};
  endfunction
  // Mirror of both registers, reserved bits never stored
  always_ff @(posedge clock) begin
    if (reset) begin
      ovr_q <= 16'h0020;
      gain_q <= 16'h0000;
    end else if (reg_wr && reg_addr == 8'h54) begin
      ovr_q <= reg_wdata & 16'h3FFF;
    end else if (reg_wr && reg_addr == 8'h55) begin
      gain_q <= reg_wdata & 16'h0FFF;
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  chk_global_cathode: assert property (
    $past(!ovr_q[7]) |-> cathode_sel == {2'h3, $past(global_cathode)}) else $error("global bias");
  chk_sleep_cathode: assert property (
    $past(ovr_q[7] && !phase[1]) |-> cathode_sel == $past(slp)) else $error("sleep bias");
  chk_slot_b_cathode: assert property (
    $past(ovr_q[7] && b) |-> cathode_sel == smap($past(ovr_q[11:10]))) else $error("B bias");
  chk_slot_a_cathode: assert property (
    $past(ovr_q[7] && phase == 2'h2) |-> cathode_sel == smap($past(ovr_q[9:8])))
    else $error("A bias");
  chk_anode_ref: assert property (
    anode_vref_sel == $past(b ? slot_b_vref : slot_a_vref)) else $error("anode ref");
  chk_ch1_main: assert property (
    ch1_rsel == 4'h1 << $past(mg)) else $error("ch1 gain");
  chk_gain_route: assert property (
    {ch4_rsel, ch3_rsel, ch2_rsel} == $past(exp_g)) else $error("ch2 to ch4 gain");
  chk_read_back: assert property (
    reg_rd |=> reg_rdata == $past(rd_exp)) else $error("read data");
  cover property (ovr_q[7] && b);
  cover property (en && phase == 2'h2);
  cover property (reg_rd && reg_addr == 8'h55);
endmodule // cbgc_chk
bind cbgc_bank cbgc_chk i_chk (.*);
`default_nettype wire

// >>> tb/testbench.sv
// Self-checking bench for the cathode bias and gain bank
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_fail++; \
  $display("mismatch at %0t: got %h want %h", $time, g, e); end end
module testbench;
  logic clock = 0, reset = 1, reg_wr = 0, reg_rd = 0, global_cathode = 0;
  logic slot_a_individual_gain_enable = 0, slot_b_individual_gain_enable = 0;
  logic [7:0] reg_addr = 0;
  logic [15:0] reg_wdata = 0;
  logic [1:0] phase = 0, slot_a_main_gain = 0, slot_b_main_gain = 0;
  logic [1:0] slot_a_vref = 0, slot_b_vref = 0, anode_vref_sel;
  logic [15:0] reg_rdata;
  logic [2:0] cathode_sel;
  logic [3:0] ch1_rsel, ch2_rsel, ch3_rsel, ch4_rsel;
  int n_fail = 0, check_count = 0;
  cbgc_bank i_dut (.*);
  initial forever #12.5 clock = ~clock;
  task automatic tick;
    @(posedge clock);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1;
    tick;
    reg_wr = 0;
    // Idle edge so a following call never re-raises the strobe in the same step
    tick;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    reg_addr = a;
    reg_rd = 1;
    tick;
    reg_rd = 0;
    `CHK(reg_rdata, e)
    tick;
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic t_regs;
    rd(8'h54, 16'h0020);
    rd(8'h55, 16'h0000);
    // Reserved bits written as zero, low field left at its default
    wr(8'h54, 16'h3F20);
    wr(8'h55, 16'h0FFF);
    wr(8'h56, 16'hFFFF);
    rd(8'h54, 16'h3F20);
    rd(8'h55, 16'h0FFF);
    rd(8'h56, 16'h0000);
    $display("regs done");
  endtask
  task automatic t_global;
    for (int i = 0; i < 8; i++) begin
      phase = i[1:0];
      global_cathode = i[2];
      tick;
      `CHK(cathode_sel, {2'h3, i[2]})
    end
    $display("global done");
  endtask
  task automatic t_cathode;
    logic [2:0] sl[4] = '{3'h0, 3'h4, 3'h5, 3'h3};
    logic [2:0] sp[4] = '{3'h0, 3'h0, 3'h2, 3'h3};
    logic [1:0] c;
    for (int i = 0; i < 4; i++) begin
      c = i[1:0];
      // Low byte is the default plus override enable bit 7
      wr(8'h54, {2'h0, c, c + 2'h1, c + 2'h2, 8'hA0});
      phase = 2'h0;
      tick;
      `CHK(cathode_sel, c == 2'h1 ? 3'h1 : sp[c])
      phase = 2'h1;
      tick;
      `CHK(cathode_sel, sp[c])
      phase = 2'h2;
      tick;
      `CHK(cathode_sel, sl[c + 2'h2])
      phase = 2'h3;
      tick;
      `CHK(cathode_sel, sl[c + 2'h1])
    end
    $display("cathode done");
  endtask
  task automatic t_gain;
    logic [1:0] mg;
    logic e;
    wr(8'h55, 16'h0E5B);
    slot_a_vref = 2'h1;
    slot_b_vref = 2'h2;
    for (int i = 0; i < 16; i++) begin
      phase = {1'b1, i[0]};
      slot_a_individual_gain_enable = i[1];
      slot_b_individual_gain_enable = !i[1];
      slot_a_main_gain = i[3:2];
      slot_b_main_gain = ~i[3:2];
      tick;
      mg = i[0] ? ~i[3:2] : i[3:2];
      e = i[0] ? !i[1] : i[1];
      `CHK(anode_vref_sel, i[0] ? 2'h2 : 2'h1)
      `CHK(ch1_rsel, 4'h1 << mg)
      `CHK({ch4_rsel, ch3_rsel, ch2_rsel}, !e ? {3{4'h1 << mg}} : i[0] ? 12'h842 : 12'h248)
    end
    $display("gain done");
  endtask
  initial begin
    repeat (4) tick;
    reset = 0;
    tick;
    t_regs;
    t_global;
    t_cathode;
    t_gain;
    tally_and_finish;
  end
  // Whole run is under 100 cycles
  initial begin
    #20000;
    n_fail++;
    tally_and_finish;
  end
endmodule // testbench
`default_nettype wire
